/* File: hdl/tsm_config_regs.sv */
// Configuration register bank of the transmitter synthesizer and modulator.
// Assumes a host that drives one-cycle read or write strobes on clk.
// Operation
// [R1] Channel 3 code 7:4, channel 4 3:0
// [R2] Feedback integer equals sixteen plus code
// [R3] Halve selects channels 1..4 at bits 3..0
// [R4] Select zero passes, one halves frequency
// [R5] Deviation step times code, scaled x4, x2
// [R6] x4 bit 7, x2 bit 6
// [R7] Bit 7 chooses FSK or ASK
// [R8] ASK applies power code to high data
// [R9] FSK applies power code as constant level
// [R10] Set-select zero uses modulation set 0
// [R11] Set-select one uses modulation set 1
// [R12] Registers read back, reset to zero
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tsm_config_regs
   import tsm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   // Transmit command set select
   input wire logic set_select,
   input wire logic tx_data,
   // Synthesizer controls
   output logic [4:0] ch3_feedback_integer,
   output logic [4:0] ch4_feedback_integer,
   output logic [3:0] halve_select,
   output logic [1:0] clock_pin_edge_speed,
   // Deviation as step count in 2^-16 units of the reference
   output logic [DEV_PRODUCT_W-1:0] deviation_steps,
   // Modulator and amplifier controls
   output logic keying_ask,
   output logic high_power_range,
   output logic [POWER_CODE_W-1:0] amp_level
);
   logic sync1_reg;
   logic sync2_reg;
   logic rst_n;
   tsm_int_type int_reg;
   tsm_deviation_scale_and_output_divide_type deviation_scale_and_output_divide_reg;
   logic [DEV_STEP_W-1:0] step_reg;
   tsm_modset_type set0_reg;
   tsm_modset_type set1_reg;
   logic [DATA_W-1:0] rdata_next;
   tsm_modset_type active_set;
   logic [DEV_PRODUCT_W-1:0] dev_next;
   logic [POWER_CODE_W-1:0] level_next;

   // Reset release through two flops keeps removal synchronous to clk.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= 1'b1;
         sync2_reg <= sync1_reg;
      end
   end
   assign rst_n = sync2_reg;

   function automatic logic [4:0] int_decode(input logic [3:0] code);
      int_decode = INT_BASE + {1'b0, code}; // [R2]
   endfunction : int_decode

   wire wr_int = reg_write && (reg_addr == ADDR_CH34_INT);
   wire wr_deviation_scale_and_output_divide = reg_write && (reg_addr == ADDR_DEV_DEVIATION_SCALE_AND_OUTPUT_DIVIDE);
   wire wr_step = reg_write && (reg_addr == ADDR_DEV_STEP);
   wire wr_set0 = reg_write && (reg_addr == ADDR_MOD_SET0);
   wire wr_set1 = reg_write && (reg_addr == ADDR_MOD_SET1);

   // One short process per register; writes to unmapped addresses match none of them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_reg <= RESET_VALUE; // [R12]
      end else if (wr_int) begin
         int_reg <= reg_wdata; // [R1]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deviation_scale_and_output_divide_reg <= RESET_VALUE; // [R12]
      end else if (wr_deviation_scale_and_output_divide) begin
         deviation_scale_and_output_divide_reg <= reg_wdata; // [R3] [R6]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_reg <= RESET_VALUE; // [R12]
      end else if (wr_step) begin
         step_reg <= reg_wdata; // [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         set0_reg <= RESET_VALUE; // [R12]
      end else if (wr_set0) begin
         set0_reg <= reg_wdata; // [R7]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         set1_reg <= RESET_VALUE; // [R12]
      end else if (wr_set1) begin
         set1_reg <= reg_wdata; // [R11]
      end
   end

   // Unmapped addresses read as zero.
   assign rdata_next = (reg_addr == ADDR_CH34_INT) ? int_reg :
                       (reg_addr == ADDR_DEV_DEVIATION_SCALE_AND_OUTPUT_DIVIDE) ? deviation_scale_and_output_divide_reg :
                       (reg_addr == ADDR_DEV_STEP) ? step_reg :
                       (reg_addr == ADDR_MOD_SET0) ? set0_reg :
                       (reg_addr == ADDR_MOD_SET1) ? set1_reg : RESET_VALUE; // [R12]

   assign active_set = set_select ? set1_reg : set0_reg; // [R10] [R11]
   wire addr_mapped = (reg_addr >= ADDR_CH34_INT) && (reg_addr <= ADDR_MOD_SET1);

   // Shift by two for x4 and one for x2; both set gives x8.
   assign dev_next = ({3'b000, step_reg}
                      << {deviation_scale_and_output_divide_reg.deviation_times_four, deviation_scale_and_output_divide_reg.deviation_times_two}); // [R5]

   // ASK drops to zero on low data; the low level belongs to another register.
   assign level_next = (active_set.keying_type == TSM_ASK) ?
                       (tx_data ? active_set.power_code : '0) : // [R8]
                       active_set.power_code; // [R9]

   // Read data stand for one cycle only and fall back to zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= RESET_VALUE;
      end else begin
         reg_rdata <= reg_read ? rdata_next : RESET_VALUE; // [R12]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ch3_feedback_integer <= INT_BASE;
      end else begin
         ch3_feedback_integer <= int_decode(int_reg.ch3_integer_code); // [R1]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ch4_feedback_integer <= INT_BASE;
      end else begin
         ch4_feedback_integer <= int_decode(int_reg.ch4_integer_code); // [R1]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halve_select <= '0;
      end else begin
         halve_select <= {deviation_scale_and_output_divide_reg.ch1_halve_select, deviation_scale_and_output_divide_reg.ch2_halve_select,
                          deviation_scale_and_output_divide_reg.ch3_halve_select, deviation_scale_and_output_divide_reg.ch4_halve_select}; // [R3]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_pin_edge_speed <= '0;
      end else begin
         clock_pin_edge_speed <= deviation_scale_and_output_divide_reg.clock_pin_edge_speed;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deviation_steps <= '0;
      end else begin
         deviation_steps <= dev_next; // [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         keying_ask <= 1'b0;
      end else begin
         keying_ask <= active_set.keying_type; // [R7]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_power_range <= 1'b0;
      end else begin
         high_power_range <= active_set.high_power_range; // [R10]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_level <= '0;
      end else begin
         amp_level <= level_next; // [R8]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // A written value reaches the derived outputs two edges later.
   sequence int_written_s;
      wr_int ##2 1;
   endsequence
   sequence deviation_scale_and_output_divide_written_s;
      wr_deviation_scale_and_output_divide ##2 1;
   endsequence
   sequence step_read_after_write_s;
      wr_step ##1 (reg_read && reg_addr == ADDR_DEV_STEP && !wr_step);
   endsequence

   int_decode_a: assert property (wr_int ##2 1 |->
      ch3_feedback_integer == 5'(INT_BASE + $past(reg_wdata[7:4], 2))) // [R2]
      else $error("Channel 3 integer wrong.");
   halve_map_a: assert property (wr_deviation_scale_and_output_divide ##2 1 |-> halve_select == $past(reg_wdata[3:0], 2))
      else $error("Halve selects wrong."); // [R3]
   dev_scale_a: assert property (##2 1 |-> deviation_steps ==
      DEV_PRODUCT_W'($past(step_reg) * ($past(deviation_scale_and_output_divide_reg[7]) ? 4 : 1)
      * ($past(deviation_scale_and_output_divide_reg[6]) ? 2 : 1))) // [R5]
      else $error("Deviation scale wrong.");
   fsk_level_a: assert property (!active_set.keying_type |=> amp_level == $past(active_set.power_code))
      else $error("FSK level wrong."); // [R9]
   ask_level_a: assert property (active_set.keying_type && tx_data |=>
      amp_level == $past(active_set.power_code)) // [R8]
      else $error("ASK level wrong.");
   set_sel0_a: assert property (!set_select |=> keying_ask == $past(set0_reg[7]))
      else $error("Set 0 not used."); // [R10]
   set_sel1_a: assert property (set_select |=> keying_ask == $past(set1_reg[7]))
      else $error("Set 1 not used."); // [R11]
   read_back_a: assert property (step_read_after_write_s // [R12]
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("Read back wrong.");
   ch4_code_a: assert property (wr_int ##2 1 |->
      ch4_feedback_integer == 5'(INT_BASE + $past(reg_wdata[3:0], 2))) // [R1]
      else $error("Channel 4 integer wrong.");

   ch3_upper_a: assert property (int_written_s |-> // [R2]
      ch3_feedback_integer >= INT_BASE)
      else $error("Channel 3 integer below base.");

   halve_ch1_a: assert property (deviation_scale_and_output_divide_written_s |-> // [R3]
      halve_select[3] == $past(reg_wdata[3], 2))
      else $error("Channel 1 halve select wrong.");

   hpr_set0_a: assert property (!set_select |=> // [R10]
      high_power_range == $past(set0_reg.high_power_range))
      else $error("Set 0 power range not used.");

   hpr_set1_a: assert property (set_select |=> // [R11]
      high_power_range == $past(set1_reg.high_power_range))
      else $error("Set 1 power range not used.");

   ask_low_a: assert property (active_set.keying_type && !tx_data |=> // [R8]
      amp_level == '0)
      else $error("ASK low level wrong.");

   dev_four_a: assert property (deviation_scale_and_output_divide_reg.deviation_times_four && !deviation_scale_and_output_divide_reg.deviation_times_two |=> // [R6]
      deviation_steps == {1'b0, $past(step_reg), 2'b00})
      else $error("Deviation x4 wrong.");

   dev_two_a: assert property (!deviation_scale_and_output_divide_reg.deviation_times_four && deviation_scale_and_output_divide_reg.deviation_times_two |=> // [R6]
      deviation_steps == {2'b00, $past(step_reg), 1'b0})
      else $error("Deviation x2 wrong.");

   dev_max_a: assert property (step_reg == '1 && deviation_scale_and_output_divide_reg[7:6] == 2'b00 |=> // [R6]
      deviation_steps == {3'b000, 8'hff})
      else $error("Largest deviation step wrong.");

   unmapped_rd_a: assert property (reg_read && !addr_mapped |=> // [R12]
      reg_rdata == RESET_VALUE)
      else $error("Unmapped read not zero.");

   idle_rdata_a: assert property (!reg_read |=> // [R12]
      reg_rdata == RESET_VALUE)
      else $error("Read data not zero when idle.");

   read_int_a: assert property (reg_read && reg_addr == ADDR_CH34_INT |=> // [R12]
      reg_rdata == $past(int_reg))
      else $error("Integer register read wrong.");

   read_deviation_scale_and_output_divide_a: assert property (reg_read && reg_addr == ADDR_DEV_DEVIATION_SCALE_AND_OUTPUT_DIVIDE |=> // [R12]
      reg_rdata == $past(deviation_scale_and_output_divide_reg))
      else $error("Divider register read wrong.");

   read_set0_a: assert property (reg_read && reg_addr == ADDR_MOD_SET0 |=> // [R12]
      reg_rdata == $past(set0_reg))
      else $error("Set 0 register read wrong.");

   read_set1_a: assert property (reg_read && reg_addr == ADDR_MOD_SET1 |=> // [R12]
      reg_rdata == $past(set1_reg))
      else $error("Set 1 register read wrong.");
endmodule : tsm_config_regs
`default_nettype wire

/* File: shared/tsm_pkg.sv */
// Package of the transmitter configuration register bank.
// Assumes one clock domain and a plain address/strobe register port.
`default_nettype none
package tsm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_CH34_INT = 8'h09;
   localparam logic [7:0] ADDR_DEV_DEVIATION_SCALE_AND_OUTPUT_DIVIDE = 8'h0a;
   localparam logic [7:0] ADDR_DEV_STEP = 8'h0b;
   localparam logic [7:0] ADDR_MOD_SET0 = 8'h0c;
   localparam logic [7:0] ADDR_MOD_SET1 = 8'h0d;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [4:0] INT_BASE = 5'h10;
   localparam int DEV_STEP_W = 8;
   localparam int DEV_PRODUCT_W = 11;
   localparam int POWER_CODE_W = 6;

   // Deviation multipliers, clock pin edge speed and output divider selects, channel 1 at bit 3.
   typedef struct packed {
      logic deviation_times_four;
      logic deviation_times_two;
      logic [1:0] clock_pin_edge_speed;
      logic ch1_halve_select;
      logic ch2_halve_select;
      logic ch3_halve_select;
      logic ch4_halve_select;
   } tsm_deviation_scale_and_output_divide_type;

   typedef struct packed {
      logic keying_type;
      logic high_power_range;
      logic [5:0] power_code;
   } tsm_modset_type;

   typedef struct packed {
      logic [3:0] ch3_integer_code;
      logic [3:0] ch4_integer_code;
   } tsm_int_type;

   typedef enum logic {
      TSM_FSK = 1'b0,
      TSM_ASK = 1'b1
   } tsm_keying_type;
endpackage : tsm_pkg
`default_nettype wire

/* File: verification/tsm_config_regs_test.sv */
// Self-checking testbench of the transmitter configuration register bank.
// Assumes the bank answers reads one cycle later and settles outputs in two.
`timescale 1ns/10ps
`default_nettype none
module tsm_config_regs_test;
   import tsm_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic set_select = 1'b0;
   logic tx_data = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] reg_rdata;
   logic [4:0] ch3_fi, ch4_fi;
   logic [3:0] halve;
   logic [1:0] edge_spd;
   logic [10:0] dev;
   logic ask, hpr;
   logic [5:0] amp;
   logic [7:0] exp_q [$];
   logic [7:0] v [5];
   logic [7:0] m;
   logic [31:0] seed = 32'h990c;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   tsm_config_regs dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .set_select(set_select),
      .tx_data(tx_data), .ch3_feedback_integer(ch3_fi), .ch4_feedback_integer(ch4_fi),
      .halve_select(halve), .clock_pin_edge_speed(edge_spd), .deviation_steps(dev),
      .keying_ask(ask), .high_power_range(hpr), .amp_level(amp));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_read <= 1'b0;
      reg_write <= 1'b1;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
   endtask : rd
   // Both strobes drop together here; wr and rd each drop the other strobe, and no signal is assigned twice in one time step.
   task automatic idle();
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      @(posedge clk);
   endtask : idle
   // Read data stand for one cycle only, so they are taken at the very next edge.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rd_seen) chk("reg_rdata", {3'h0, exp_q.pop_front()}, {3'h0, reg_rdata});
      rd_seen <= reg_read;
      if (cyc == 4000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("ch3_fi", 11'h10, {6'h0, ch3_fi});
      chk("amp", 11'h0, {5'h0, amp});
      @(posedge clk);
      for (int k = 0; k < 5; k++) rd(8'(ADDR_CH34_INT + k), RESET_VALUE);
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h00);
      idle();
      $display("test reset and unmapped done");
      for (int i = 0; i < 20; i++) begin
         for (int k = 0; k < 5; k++) begin
            seed = xs(seed);
            v[k] = seed[7:0];
         end
         // The first four passes take the largest step code under each multiplier pair.
         if (i < 4) begin
            v[1][7:6] = i[1:0];
            v[2] = 8'hff;
         end
         set_select <= seed[8];
         tx_data <= seed[9];
         for (int k = 0; k < 5; k++) wr(8'(ADDR_CH34_INT + k), v[k]);
         for (int k = 0; k < 5; k++) rd(8'(ADDR_CH34_INT + k), v[k]);
         idle();
         #1 m = seed[8] ? v[4] : v[3];
         chk("ch3_fi", {6'h0, 1'b1, v[0][7:4]}, {6'h0, ch3_fi});
         chk("ch4_fi", {6'h0, 1'b1, v[0][3:0]}, {6'h0, ch4_fi});
         chk("halve", {7'h0, v[1][3:0]}, {7'h0, halve});
         chk("edge_spd", {9'h0, v[1][5:4]}, {9'h0, edge_spd});
         chk("dev", {3'h0, v[2]} << (2 * v[1][7] + v[1][6]), dev);
         chk("ask", {10'h0, m[7]}, {10'h0, ask});
         chk("hpr", {10'h0, m[6]}, {10'h0, hpr});
         chk("amp", (m[7] && !seed[9]) ? 11'h0 : {5'h0, m[5:0]}, {5'h0, amp});
         @(posedge clk);
      end
      $display("test random settings done");
      @(posedge clk);
      end_of_test();
   end
endmodule : tsm_config_regs_test
`default_nettype wire
